// file: hw/led_plane_pkg.sv
package led_plane_pkg;

    // register addresses of the serial word
    localparam logic [7:0] ADDR_NOOP        = 8'h00;
    localparam logic [7:0] ADDR_SCAN_LIMIT  = 8'h03;
    localparam logic [7:0] ADDR_CONFIG      = 8'h04;
    localparam logic [7:0] ADDR_LAMP_TEST   = 8'h07;
    localparam logic [7:0] ADDR_DIGIT_MASK  = 8'hF8;
    localparam logic [7:0] ADDR_PRIMARY     = 8'h20;
    localparam logic [7:0] ADDR_ALTERNATE   = 8'h40;
    localparam logic [7:0] ADDR_BOTH        = 8'h60;

    // configuration field positions
    localparam int CFG_SHUTDOWN_N_BIT = 0;
    localparam int CFG_RATE_BIT       = 2;
    localparam int CFG_BLINK_EN_BIT   = 3;
    localparam int CFG_SYNC_BIT       = 4;
    localparam int CFG_CLEAR_BIT      = 5;
    localparam int LAMP_TEST_BIT      = 0;

    // reset values
    localparam logic [7:0] CONFIG_RESET     = 8'h00;
    localparam logic [2:0] SCAN_RESET       = 3'h4;
    localparam logic [7:0] DIGIT_RESET      = 8'h00;
    localparam logic [2:0] SCAN_ALL         = 3'h7;

    // geometry
    localparam int DIGITS     = 8;
    localparam int DIGIT_BITS = 3;
    localparam int WORD_BITS  = 16;

    // multiplex clock: 4 MHz nominal, one digit slot of 800 cycles is 200 us
    localparam int MUX_CLK_HZ      = 4_000_000;
    localparam int SLOW_HALF_MS    = 1000;
    localparam int FAST_HALF_MS    = 500;
    localparam int SLOT_US         = 200;
    localparam int SLOW_HALF_TICKS = MUX_CLK_HZ / 1000 * SLOW_HALF_MS;
    localparam int FAST_HALF_TICKS = MUX_CLK_HZ / 1000 * FAST_HALF_MS;
    localparam int SLOT_TICKS      = MUX_CLK_HZ / 1_000_000 * SLOT_US;

    // serial receiver states
    typedef enum logic [1:0]
    {
        RX_IDLE  = 2'b00,
        RX_SHIFT = 2'b01,
        RX_DONE  = 2'b10
    } rx_state_t;

endpackage

// file: hw/plane_store.sv
`timescale 1ns/1ps

// two-plane digit store: one write port from the serial side, two read ports for the scan
module plane_store
    import led_plane_pkg::*;
(
    input  wire logic                  core_clk_i,
    input  wire logic                  rstn_i,
    input  wire logic                  clear_i,      // wipe both planes
    input  wire logic                  wr_primary_i, // write primary plane
    input  wire logic                  wr_alt_i,     // write alternate plane
    input  wire logic [DIGIT_BITS-1:0] wr_idx_i,     // digit written
    input  wire logic [7:0]            wr_data_i,    // segment byte
    input  wire logic [DIGIT_BITS-1:0] rd_idx_i,     // digit being scanned
    output logic      [7:0]            rd_primary_o, // primary plane byte
    output logic      [7:0]            rd_alt_o      // alternate plane byte
);

    logic [7:0] primary_plane   [DIGITS];   // primary plane bytes
    logic [7:0] alternate_plane [DIGITS];   // alternate plane bytes

    ////////////////////////////////////////////////////////////////////////
    // one entry per digit; write side and read side are independent
    genvar g;
    generate
        for (g = 0; g < DIGITS; g++)
        begin : g_digit
            // entry update: clear wins over a write
            always_ff @(posedge core_clk_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    primary_plane[g]   <= DIGIT_RESET;
                    alternate_plane[g] <= DIGIT_RESET;
                end
                else if (clear_i)
                begin
                    primary_plane[g]   <= DIGIT_RESET;
                    alternate_plane[g] <= DIGIT_RESET;
                end
                else if (wr_idx_i == DIGIT_BITS'(g))
                begin
                    // one or both planes per address group
                    if (wr_primary_i)
                        primary_plane[g] <= wr_data_i;
                    if (wr_alt_i)
                        alternate_plane[g] <= wr_data_i;
                end
            end
        end
    endgenerate

    // read ports for the scan, separate from the write port
    assign rd_primary_o = primary_plane[rd_idx_i];
    assign rd_alt_o     = alternate_plane[rd_idx_i];

endmodule

// file: hw/led_blink_plane_config.sv
`timescale 1ns/1ps

// Summary of operation
// - two planes of eight digit bytes
// - plane writes independent of scan reads
// - config bits R T E B 0 S
// - S zero means shutdown, one normal
// - rate bit: 1s slow, 0.5s fast
// - E bit enables blinking
// - T bit clears blink counters at select rise
// - R bit clears both planes at select rise
// - test register bit0 selects lamp test
// - scan limit bits 2:0 give last digit
// - each segment has one bit per plane
// - write primary, alternate or both planes
// - blink off shows primary plane only
// - blink on alternates planes each phase
// - blinking runs on without host writes
// - blink period divided from multiplex clock
// - digit addresses 0x20, 0x40, 0x60 plus index
// - reset clears config and all digits
// - sync also restarts divider and scan
// - lamp test lights all, scans eight digits
module led_blink_plane_config
    import led_plane_pkg::*;
#(
    parameter int SLOW_HALF = SLOW_HALF_TICKS,  // multiplex ticks per slow phase
    parameter int FAST_HALF = FAST_HALF_TICKS,  // multiplex ticks per fast phase
    parameter int SLOT      = SLOT_TICKS        // multiplex ticks per digit slot
)
(
    input  wire logic                  core_clk_i,
    input  wire logic                  rstn_i,
    input  wire logic                  ser_sclk_i,            // serial clock, sampled
    input  wire logic                  ser_csn_i,             // chip select, active low
    input  wire logic                  ser_mosi_i,            // serial data in, msb first
    input  wire logic                  multiplex_clock_input, // multiplex oscillator level
    output logic                       shutdown_o,            // display off
    output logic                       blink_phase_o,         // high in the alternate plane phase, even with blinking off
    output logic      [DIGIT_BITS-1:0] digit_sel_o,           // digit being scanned
    output logic      [7:0]            segments_o,            // segment levels for that digit
    output logic                       lamp_test_o            // lamp test active
);

    import led_plane_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // serial receiver
    // pins are levels sampled on the core clock
    // an edge is a change between two samples
    // each serial level must last one core cycle
    // the word is msb first: address, then data
    // missing bits spoil the word, and so do extra bits unless they are a multiple of 33

    // receiver registers and decode nets
    logic                  sclk_d_r;      // previous serial clock level
    logic                  csn_d_r;       // previous select level
    logic [WORD_BITS-1:0]  shift_r;       // incoming word
    logic [4:0]            bit_cnt_r;     // bits taken this frame
    rx_state_t             rx_state_r;    // receiver state
    logic                  sclk_rise;     // serial clock edge seen
    logic                  cs_rise;       // end of frame
    logic                  word_ok;       // full word at frame end
    logic [7:0]            word_addr;     // address byte
    logic [7:0]            word_data;     // data byte

    // serial clock rose: take one bit
    assign sclk_rise = ser_sclk_i & ~sclk_d_r;
    // select rose: the frame has closed
    assign cs_rise   = ser_csn_i & ~csn_d_r;
    // address and data halves of the word
    assign word_addr = shift_r[15:8];
    assign word_data = shift_r[7:0];
    // commit a frame of sixteen bits, or of sixteen plus a multiple of 33 once the count wraps
    assign word_ok   = cs_rise && (rx_state_r == RX_DONE);

    // edge history of the serial pins
    // reset levels match the idle pins, no false edge
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sclk_d_r <= 1'b0;
            csn_d_r  <= 1'b1;
        end
        else
        begin
            sclk_d_r <= ser_sclk_i;
            csn_d_r  <= ser_csn_i;
        end
    end

    // frame state: a word counts if sixteen bits came in, or sixteen plus a multiple of 33 once the five-bit count wraps
    // an early select rise drops the word, and so does a late one at any other count
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rx_state_r <= RX_IDLE;
            bit_cnt_r  <= 5'd0;
            shift_r    <= 16'h0000;
        end
        else if (ser_csn_i)
        begin
            // deselected: ready for next frame
            // the shift register keeps its bits for the commit
            rx_state_r <= RX_IDLE;
            bit_cnt_r  <= 5'd0;
        end
        else if (sclk_rise)
        begin
            // shift in at the bottom, msb first
            shift_r <= {shift_r[WORD_BITS-2:0], ser_mosi_i};
            case (rx_state_r)
                RX_IDLE, RX_SHIFT:
                begin
                    // count the bit just taken
                    bit_cnt_r  <= bit_cnt_r + 5'd1;
                    // sixteenth bit completes the word
                    rx_state_r <= (bit_cnt_r == 5'd15) ? RX_DONE : RX_SHIFT;
                end
                RX_DONE:
                begin
                    // surplus bits spoil the word
                    // and the count restarts at sixteen and keeps counting
                    rx_state_r <= RX_SHIFT;
                    bit_cnt_r  <= 5'd16;
                end
                default:
                    rx_state_r <= RX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register decode, all committed at select rise
    // each write strobe lasts one core cycle
    // unknown addresses, no-op included, fall through
    // digit groups share the low three address bits
    // address bits 5 and 6 pick primary and alternate

    // write strobes and stored settings
    logic       wr_cfg;       // configuration write
    logic       wr_scan;      // scan limit write
    logic       wr_test;      // lamp test write
    logic       wr_digit;     // digit group write
    logic       plane_clear;  // clear both planes
    logic       timer_sync;   // restart divider, blink and scan
    logic [7:0] cfg_r;        // display_configuration
    logic [2:0] scan_r;       // scan_digit_count
    logic       test_r;       // lamp_test_control

    assign wr_cfg      = word_ok && (word_addr == ADDR_CONFIG);
    assign wr_scan     = word_ok && (word_addr == ADDR_SCAN_LIMIT);
    assign wr_test     = word_ok && (word_addr == ADDR_LAMP_TEST);
    assign wr_digit    = word_ok && ((word_addr & ADDR_DIGIT_MASK) == ADDR_PRIMARY
                                  || (word_addr & ADDR_DIGIT_MASK) == ADDR_ALTERNATE
                                  || (word_addr & ADDR_DIGIT_MASK) == ADDR_BOTH);
    assign plane_clear = wr_cfg && word_data[CFG_CLEAR_BIT];
    assign timer_sync  = wr_cfg && word_data[CFG_SYNC_BIT];

    // control registers take the word only when the frame closes
    // unused config bits are stored as zero
    // the clear and sync bits are kept as written
    // reset: shutdown, slow rate, blink off
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cfg_r  <= CONFIG_RESET;
            scan_r <= SCAN_RESET;
            test_r <= 1'b0;
        end
        else
        begin
            if (wr_cfg)
                cfg_r <= {2'b00, word_data[5:2], 1'b0, word_data[0]};
            // only three limit bits are kept
            if (wr_scan)
                scan_r <= word_data[2:0];
            // only the test bit is kept
            if (wr_test)
                test_r <= word_data[LAMP_TEST_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // digit store
    // the planes live in the store module
    // the scan reads while the host writes
    // a clear in the same word beats a digit write

    logic [7:0] rd_primary;   // primary byte of scanned digit
    logic [7:0] rd_alt;       // alternate byte of scanned digit

    plane_store u_store
    (
        .core_clk_i   (core_clk_i),
        .rstn_i       (rstn_i),
        .clear_i      (plane_clear),
        .wr_primary_i (wr_digit && word_addr[5]),
        .wr_alt_i     (wr_digit && word_addr[6]),
        .wr_idx_i     (word_addr[DIGIT_BITS-1:0]),
        .wr_data_i    (word_data),
        .rd_idx_i     (digit_sel_o),
        .rd_primary_o (rd_primary),
        .rd_alt_o     (rd_alt)
    );

    ////////////////////////////////////////////////////////////////////////
    // multiplex clock tick, blink timer and scan
    // the oscillator pin is a sampled level
    // each rising level is one multiplex tick
    // phase and slot counts run in ticks only
    // half_len picks the slow or fast phase
    // lamp test widens the scan to all digits

    // tick, counters and scan bound
    logic        osc_d_r;      // previous oscillator level
    logic        osc_tick;     // one multiplex clock rising edge
    logic [31:0] blink_cnt_r;  // ticks in current blink phase
    logic [31:0] slot_cnt_r;   // ticks in current digit slot
    logic [31:0] half_len;     // ticks per blink phase
    logic [2:0]  last_digit;   // final digit of the scan

    assign osc_tick   = multiplex_clock_input & ~osc_d_r;
    assign half_len   = cfg_r[CFG_RATE_BIT] ? 32'(FAST_HALF) : 32'(SLOW_HALF);
    assign last_digit = test_r ? SCAN_ALL : scan_r;

    // oscillator edge history
    // reset at the pin's low level
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            osc_d_r <= 1'b0;
        else
            osc_d_r <= multiplex_clock_input;
    end

    // blink divider: free running phase flips, whole display at once
    // the timer runs with blinking off as well
    // a rate change takes effect at the next tick
    // sync clears the count and the phase
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            blink_cnt_r   <= 32'd0;
            blink_phase_o <= 1'b0;
        end
        else if (timer_sync)
        begin
            // sync restarts the phase at its start
            blink_cnt_r   <= 32'd0;
            blink_phase_o <= 1'b0;
        end
        else if (osc_tick)
        begin
            if (blink_cnt_r >= half_len - 32'd1)
            begin
                blink_cnt_r   <= 32'd0;
                // phase over: flip the plane choice
                blink_phase_o <= ~blink_phase_o;
            end
            else
                // still inside the phase
                blink_cnt_r <= blink_cnt_r + 32'd1;
        end
    end

    // digit scan from 0 to last digit
    // the scan keeps running in shutdown
    // a lowered limit wraps at the next slot end
    // sync sends the scan back to digit 0
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            slot_cnt_r  <= 32'd0;
            digit_sel_o <= 3'd0;
        end
        else if (timer_sync)
        begin
            // scan starts again at digit 0
            slot_cnt_r  <= 32'd0;
            digit_sel_o <= 3'd0;
        end
        else if (osc_tick)
        begin
            if (slot_cnt_r >= 32'(SLOT) - 32'd1)
            begin
                slot_cnt_r  <= 32'd0;
                // slot over: next digit, or wrap
                digit_sel_o <= (digit_sel_o >= last_digit) ? 3'd0 : digit_sel_o + 3'd1;
            end
            else
                // still inside the slot
                slot_cnt_r <= slot_cnt_r + 32'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // segment drive
    // one register stage after digit and phase
    // lamp test overrides but never rewrites

    // plane choice, lamp test and shutdown override
    // outputs lag the settings by one cycle
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            segments_o  <= 8'h00;
            shutdown_o  <= 1'b1;
            lamp_test_o <= 1'b0;
        end
        else
        begin
            // status copies of the live settings
            lamp_test_o <= test_r;
            // lamp test overrides shutdown without touching it
            shutdown_o  <= ~test_r && ~cfg_r[CFG_SHUTDOWN_N_BIT];
            // lamp test: every segment lit
            if (test_r)
                segments_o <= 8'hFF;
            // shutdown: all dark
            else if (!cfg_r[CFG_SHUTDOWN_N_BIT])
                segments_o <= 8'h00;
            // blinking, alternate phase
            else if (cfg_r[CFG_BLINK_EN_BIT] && blink_phase_o)
                segments_o <= rd_alt;
            // otherwise the primary plane
            else
                segments_o <= rd_primary;
        end
    end

endmodule

// file: test/led_plane_checker_properties.sv
`timescale 1ns/1ps

// port checks: reset state, overrides, commit timing, scan and blink pacing
module led_plane_checker
#(
    parameter int SLOT      = 2, // ticks per digit slot
    parameter int FAST_HALF = 4  // ticks per fast blink phase
)
(
    input wire logic                                 core_clk_i,
    input wire logic                                 rstn_i,
    input wire logic                                 ser_csn_i,
    input wire logic                                 multiplex_clock_input,
    input wire logic                                 shutdown_o,
    input wire logic                                 blink_phase_o,
    input wire logic [led_plane_pkg::DIGIT_BITS-1:0] digit_sel_o,
    input wire logic [7:0]                           segments_o,
    input wire logic                                 lamp_test_o
);
    import led_plane_pkg::*;

    logic       mux_q_r;       // multiplex level one cycle back
    logic       tick;          // multiplex rising edge
    logic [3:0] quiet_r;       // cycles with select high, saturating
    logic [7:0] slot_ticks_r;  // ticks since the digit moved
    logic [7:0] phase_ticks_r; // ticks since the phase moved

    assign tick = multiplex_clock_input && !mux_q_r;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    //////////////////////////////////////////
    // edge detect and select-high count; a commit lands a few cycles into it
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            mux_q_r <= 1'b0;
            quiet_r <= 4'hF;
        end
        else
        begin
            mux_q_r <= multiplex_clock_input;
            quiet_r <= ser_csn_i ? quiet_r + 4'(quiet_r != 4'hF) : 4'h0;
        end
    end

    // ticks seen since the digit and the phase last changed
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            slot_ticks_r  <= 8'h00;
            phase_ticks_r <= 8'h00;
        end
        else
        begin
            slot_ticks_r  <= $changed(digit_sel_o) ? 8'h00 : slot_ticks_r + 8'(tick && slot_ticks_r != 8'hFF);
            phase_ticks_r <= $changed(blink_phase_o) ? 8'h00 : phase_ticks_r + 8'(tick && phase_ticks_r != 8'hFF);
        end
    end

    //////////////////////////////////////////
    property p_reset_state;
        $rose(rstn_i) |-> shutdown_o && !lamp_test_o && !blink_phase_o && digit_sel_o == 3'h0 && segments_o == 8'h00;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("outputs off reset state");

    property p_lamp_all_on;
        lamp_test_o && $past(lamp_test_o) |-> segments_o == 8'hFF;
    endproperty
    a_lamp_all_on: assert property (p_lamp_all_on) else $error("lamp test not all on");

    property p_shutdown_dark;
        shutdown_o && $past(shutdown_o) && !lamp_test_o && !$past(lamp_test_o) |-> segments_o == 8'h00;
    endproperty
    a_shutdown_dark: assert property (p_shutdown_dark) else $error("segments lit in shutdown");

    property p_scan_step;
        $changed(digit_sel_o) && quiet_r > 4'h5 |-> digit_sel_o == $past(digit_sel_o) + 3'h1 || digit_sel_o == 3'h0;
    endproperty
    a_scan_step: assert property (p_scan_step) else $error("digit skipped");

    property p_test_scans_eight;
        lamp_test_o && $past(lamp_test_o) && $changed(digit_sel_o) && digit_sel_o == 3'h0 && quiet_r > 4'h5
            |-> $past(digit_sel_o) == 3'h7;
    endproperty
    a_test_scans_eight: assert property (p_test_scans_eight) else $error("lamp test wrapped early");

    property p_commit_after_select;
        $changed(shutdown_o) || $changed(lamp_test_o) |-> quiet_r inside {[4'h1:4'h5]};
    endproperty
    a_commit_after_select: assert property (p_commit_after_select) else $error("setting moved off commit");

    property p_slot_length;
        $changed(digit_sel_o) && quiet_r > 4'h5 |-> slot_ticks_r >= 8'(SLOT);
    endproperty
    a_slot_length: assert property (p_slot_length) else $error("digit slot too short");

    property p_phase_length;
        $changed(blink_phase_o) && quiet_r > 4'h5 |-> phase_ticks_r >= 8'(FAST_HALF);
    endproperty
    a_phase_length: assert property (p_phase_length) else $error("blink phase too short");
endmodule

bind led_blink_plane_config led_plane_checker #(.SLOT(SLOT), .FAST_HALF(FAST_HALF)) u_checker
(
    .core_clk_i, .rstn_i, .ser_csn_i, .multiplex_clock_input, .shutdown_o,
    .blink_phase_o, .digit_sel_o, .segments_o, .lamp_test_o
);

// file: test/led_host_model.sv
`timescale 1ns/1ps

// host end of the serial link: address byte then data byte, msb first
module led_host_model
(
    input  wire logic core_clk_i, // paces the serial timing
    output logic      ser_sclk_o, // serial clock, low between frames
    output logic      ser_csn_o,  // chip select, active low
    output logic      ser_mosi_o  // serial data to the block
);
    import led_plane_pkg::*;

    // idle link at time zero
    initial
    begin
        ser_sclk_o = 1'b0;
        ser_csn_o  = 1'b1;
        ser_mosi_o = 1'b0;
    end

    // n core edges, then the drive delay
    task automatic step(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    // sends the top nbits of the word; half sets the serial clock half period
    task automatic send(input logic [7:0] addr, input logic [7:0] data, input int nbits, input int half);
        logic [15:0] w;
        if (addr == ADDR_CONFIG)
            data[1] = 1'b0;
        w = {addr, data};
        step(1);
        ser_csn_o = 1'b0;
        for (int i = 15; i > 15 - nbits; i--)
        begin
            ser_mosi_o = w[i];
            step(half);
            ser_sclk_o = 1'b1;
            step(half);
            ser_sclk_o = 1'b0;
        end
        ser_csn_o  = 1'b1;
        ser_mosi_o = ~ser_mosi_o; // released line drops the last bit
        step(4);
    endtask
endmodule

// file: test/tb.sv
`timescale 1ns/1ps

// bench top: frames through the host model, segments checked per digit and phase
module tb;
    import led_plane_pkg::*;

    localparam int SLOW = 8; // ticks per slow phase
    localparam int FAST = 4; // ticks per fast phase
    localparam int SLT  = 2; // ticks per digit slot
    localparam int TICK = 8; // core cycles per multiplex tick

    logic       clk;         // core clock
    logic       rstn;        // reset, active low
    logic       sclk;        // serial clock from host
    logic       csn;         // chip select from host
    logic       mosi;        // serial data from host
    logic [2:0] mux_div_r;   // core clock divided to the multiplex rate
    logic       shutdown;    // display off
    logic       blink_phase; // alternate plane phase
    logic [2:0] digit_sel;   // scanned digit
    logic [7:0] segments;    // shown byte
    logic       lamp_test;   // lamp test active
    int         mismatches;  // failed comparisons
    int         n_tests;     // comparisons made

    led_host_model host
    (
        .core_clk_i (clk),
        .ser_sclk_o (sclk),
        .ser_csn_o  (csn),
        .ser_mosi_o (mosi)
    );

    led_blink_plane_config #(.SLOW_HALF(SLOW), .FAST_HALF(FAST), .SLOT(SLT)) uut
    (
        .core_clk_i            (clk),
        .rstn_i                (rstn),
        .ser_sclk_i            (sclk),
        .ser_csn_i             (csn),
        .ser_mosi_i            (mosi),
        .multiplex_clock_input (mux_div_r[2]),
        .shutdown_o            (shutdown),
        .blink_phase_o         (blink_phase),
        .digit_sel_o           (digit_sel),
        .segments_o            (segments),
        .lamp_test_o           (lamp_test)
    );

    // 200 MHz core clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // multiplex ticks every TICK core cycles
    always @(posedge clk)
        mux_div_r <= mux_div_r + 3'h1;

    // one comparison; a mismatch is reported and counted
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // n core edges, then the drive delay
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // verdict and end of run
    task automatic print_verdict();
        if (mismatches == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // waits until the digit, or the phase, newly takes value v; bounded
    task automatic wait_on(input logic by_phase, input logic [2:0] v);
        logic [2:0] now;
        logic [2:0] prev;
        prev = v;
        for (int n = 0; n < 600; n++)
        begin
            now = by_phase ? {2'h0, blink_phase} : digit_sel;
            if (now === v && prev !== v)
                return;
            prev = now;
            cyc(1);
        end
        mismatches++;
        $display("[FAIL] wait expected %h seen timeout", v);
        print_verdict();
    endtask

    // byte shown once the digit or phase is entered
    task automatic seg_on(input string what, input logic by_phase, input logic [2:0] v, input logic [7:0] exp);
        wait_on(by_phase, v);
        cyc(2);
        chk(what, exp, segments);
    endtask

    // core cycles spent in one alternate phase
    task automatic phase_len(input string what, input int exp);
        int n;
        wait_on(1'b1, 3'h1);
        for (n = 0; n < 300 && blink_phase === 1'b1; n++)
            cyc(1);
        chk(what, 8'(exp), 8'(n));
    endtask

    // main sequence
    initial
    begin
        rstn       = 1'b0;
        mux_div_r  = 3'h0;
        mismatches = 0;
        n_tests    = 0;
        cyc(12);
        rstn = 1'b1;
        cyc(1);
        chk("shutdown at reset", 8'h01, 8'(shutdown));
        host.send(ADDR_CONFIG, 8'h01, 16, 2);
        seg_on("blank digit 2", 1'b0, 3'h2, 8'h00);
        host.send(ADDR_SCAN_LIMIT, 8'hF7, 16, 5);
        host.send(ADDR_PRIMARY, 8'h11, 16, 2);
        host.send(ADDR_ALTERNATE, 8'h22, 16, 2);
        host.send(ADDR_BOTH | 8'h07, 8'h5A, 16, 2);
        host.send(ADDR_PRIMARY | 8'h01, 8'h77, 15, 2);
        seg_on("primary digit 0", 1'b0, 3'h0, 8'h11);
        seg_on("short frame digit 1", 1'b0, 3'h1, 8'h00);
        seg_on("both planes digit 7", 1'b0, 3'h7, 8'h5A);
        host.send(ADDR_SCAN_LIMIT, 8'h00, 16, 2);
        host.send(ADDR_CONFIG, 8'h09, 16, 2);
        phase_len("slow phase", SLOW * TICK);
        seg_on("alternate phase", 1'b1, 3'h1, 8'h22);
        seg_on("primary phase", 1'b1, 3'h0, 8'h11);
        host.send(ADDR_CONFIG, 8'h0D, 16, 2);
        phase_len("fast phase", FAST * TICK);
        host.send(ADDR_CONFIG, 8'h01, 16, 2);
        seg_on("blink off", 1'b1, 3'h1, 8'h11);
        chk("scan limit zero", 8'h00, 8'(digit_sel));
        host.send(ADDR_SCAN_LIMIT, 8'h03, 16, 2);
        host.send(ADDR_CONFIG, 8'h00, 16, 2);
        seg_on("shutdown digit 0", 1'b0, 3'h0, 8'h00);
        host.send(ADDR_LAMP_TEST, 8'h01, 16, 2);
        seg_on("lamp test digit 6", 1'b0, 3'h6, 8'hFF);
        host.send(ADDR_LAMP_TEST, 8'hFE, 16, 2);
        chk("lamp test off", 8'h00, 8'(lamp_test));
        host.send(ADDR_CONFIG, 8'h01, 16, 2);
        seg_on("digit 0 kept", 1'b0, 3'h0, 8'h11);
        host.send(ADDR_CONFIG, 8'h1D, 16, 2);
        cyc(4);
        chk("sync digit", 8'h00, 8'(digit_sel));
        chk("sync phase", 8'h00, 8'(blink_phase));
        host.send(ADDR_CONFIG, 8'h21, 16, 2);
        seg_on("cleared digit 0", 1'b0, 3'h0, 8'h00);
        print_verdict();
    end
endmodule
